/* rtl/tsco_core.sv */
// Configuration register file, conversion sequencer, offset, fault and hottest logic.
`timescale 1ns/1ns
module tsco_core #(
    parameter int NUM_CH = 4
) (
    input  wire logic                                       clock,
    input  wire logic                                       rst,
    input  wire tsco_pkg::tsco_req_t                        reg_req,
    output logic [7:0]                                      rd_data,
    output logic                                            conv_enable,
    output logic                                            conv_start,
    output logic [tsco_pkg::CH_W-1:0]                       conv_channel,
    output logic                                            conv_ideal_custom,
    input  wire logic                                       conv_done,
    input  wire logic [tsco_pkg::TEMP_W-1:0]                conv_temp,
    input  wire logic [NUM_CH-1:0][tsco_pkg::TEMP_W-1:0]    limit_temp,
    input  wire logic [NUM_CH-1:0][tsco_pkg::TEMP_W-1:0]    ref_temp,
    input  wire logic [NUM_CH-1:0]                          hot_enable,
    input  wire logic                                       alert_ack,
    output logic [NUM_CH-1:0][tsco_pkg::TEMP_W-1:0]         result,
    output logic [tsco_pkg::TEMP_W:0]                       hottest,
    output logic [NUM_CH-1:0]                               fault,
    output logic                                            therm_alert,
    output logic                                            bus_timeout_en
);
    localparam int TW = tsco_pkg::TEMP_W;
    localparam logic [tsco_pkg::CH_W-1:0] LAST_CH = tsco_pkg::CH_W'(NUM_CH - 1);

    if (NUM_CH < 2 || NUM_CH > 4) begin : g_bad_ch
        $error("NUM_CH must lie between 2 and 4.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    tsco_pkg::tsco_cfg_t         cfg_reg;
    logic [7:0]                  ideal_en_reg;
    logic [7:0]                  offset_reg;
    logic [7:0]                  offset_en_reg;
    logic [7:0]                  rd_data_reg;
    tsco_pkg::tsco_seq_t         state_reg;
    tsco_pkg::tsco_seq_t         state_next;
    logic [tsco_pkg::CH_W-1:0]   ch_reg;
    logic                        conv_start_reg;
    logic                        conv_enable_reg;
    logic                        conv_ideal_reg;
    logic                        timeout_en_reg;
    logic [NUM_CH-1:0][TW-1:0]   raw_reg;
    logic [NUM_CH-1:0][TW-1:0]   result_reg;
    logic [NUM_CH-1:0][2:0]      cnt_reg;
    logic [NUM_CH-1:0]           fault_reg;
    logic [NUM_CH-1:0]           fault_next;
    logic                        alert_reg;
    logic [TW:0]                 hot_reg;
    logic [TW:0]                 hot_next;

    ////////////////////////////////////////////////////////////////////////////////
    wire wr_cfg       = reg_req.wr && reg_req.addr == tsco_pkg::ADDR_CONFIG;
    wire wr_ideal     = reg_req.wr && reg_req.addr == tsco_pkg::ADDR_IDEAL_EN;
    wire wr_offset    = reg_req.wr && reg_req.addr == tsco_pkg::ADDR_OFFSET;
    wire wr_offset_en = reg_req.wr && reg_req.addr == tsco_pkg::ADDR_OFFSET_EN;
    wire wr_single    = wr_cfg && reg_req.data[tsco_pkg::SINGLE_BIT];
    // A trigger outside standby is dropped together with the rest of the byte.
    wire cfg_single   = wr_single && cfg_reg.standby;
    wire cfg_plain    = wr_cfg && !reg_req.data[tsco_pkg::SINGLE_BIT];
    wire init         = rst || (cfg_plain && reg_req.data[tsco_pkg::REINIT_BIT]);
    wire run          = !cfg_reg.standby || cfg_reg.single_conversion_trigger;
    wire done_hit     = state_reg == tsco_pkg::SEQ_WAIT && conv_done;
    wire round_done   = done_hit && ch_reg == LAST_CH;
    wire abort        = state_reg == tsco_pkg::SEQ_WAIT && !run;
    wire [2:0] need   = tsco_pkg::fault_need(cfg_reg.fault_queue);

    wire [7:0] rd_mux =
        reg_req.addr == tsco_pkg::ADDR_CONFIG    ? 8'(cfg_reg) :
        reg_req.addr == tsco_pkg::ADDR_IDEAL_EN  ? ideal_en_reg :
        reg_req.addr == tsco_pkg::ADDR_OFFSET    ? offset_reg :
        reg_req.addr == tsco_pkg::ADDR_OFFSET_EN ? offset_en_reg : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Offset is code times two sixteenths plus the negative base, so 77h gives zero.
    wire [TW:0] offset_val = {5'h00, offset_reg, 1'b0} + tsco_pkg::OFFSET_BASE;
    wire        apply_off  = offset_en_reg[ch_reg] && ch_reg != '0;
    wire [TW:0] corr_sum   = {conv_temp[TW-1], conv_temp} + (apply_off ? offset_val : '0);
    wire [TW-1:0] span_max = cfg_reg.wide_span_select ? tsco_pkg::MAX_WIDE
                                                      : tsco_pkg::MAX_NORMAL;
    wire over_max  = $signed(corr_sum) > $signed({span_max[TW-1], span_max});
    wire under_min = $signed(corr_sum) < $signed({1'b1, tsco_pkg::TEMP_MIN});
    wire [TW-1:0] corr_val = over_max  ? span_max :
                             under_min ? tsco_pkg::TEMP_MIN : corr_sum[TW-1:0];
    wire exceed = $signed(corr_val) > $signed(limit_temp[ch_reg]);
    wire [2:0] cnt_cur = cnt_reg[ch_reg];
    wire [2:0] cnt_upd = !exceed       ? 3'h0 :
                         cnt_cur >= need ? need : 3'(cnt_cur + 3'h1);
    wire fault_rise = |(fault_next & ~fault_reg);

    always_comb begin
        fault_next = fault_reg;
        if (done_hit) begin
            fault_next[ch_reg] = cnt_upd >= need;
        end
    end

    // Built from the uncorrected samples so the offset never reaches it.
    always_comb begin
        logic [TW:0] diff;
        logic        found;
        diff     = '0;
        found    = 1'b0;
        hot_next = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            diff = {raw_reg[i][TW-1], raw_reg[i]} - {ref_temp[i][TW-1], ref_temp[i]};
            if (hot_enable[i] && (!found || $signed(diff) > $signed(hot_next))) begin
                hot_next = diff;
                found    = 1'b1;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            tsco_pkg::SEQ_IDLE:  if (run) state_next = tsco_pkg::SEQ_START;
            tsco_pkg::SEQ_START: state_next = tsco_pkg::SEQ_WAIT;
            tsco_pkg::SEQ_WAIT: begin
                if (abort || round_done) begin
                    state_next = tsco_pkg::SEQ_IDLE;
                end else if (done_hit) begin
                    state_next = tsco_pkg::SEQ_START;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock) begin
        if (init) begin
            cfg_reg <= tsco_pkg::tsco_cfg_t'(tsco_pkg::CONFIG_RST);
        end else if (cfg_single) begin
            cfg_reg.single_conversion_trigger <= 1'b1;
        end else if (cfg_plain) begin
            cfg_reg <= tsco_pkg::tsco_cfg_t'(reg_req.data & tsco_pkg::CONFIG_WR_MASK);
        end else if (round_done) begin
            cfg_reg.single_conversion_trigger <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (init) begin
            ideal_en_reg  <= tsco_pkg::CH_EN_RST;
            offset_reg    <= tsco_pkg::OFFSET_RST;
            offset_en_reg <= tsco_pkg::CH_EN_RST;
        end else begin
            if (wr_ideal) ideal_en_reg <= reg_req.data & tsco_pkg::CH_EN_MASK;
            if (wr_offset) offset_reg <= reg_req.data;
            if (wr_offset_en) offset_en_reg <= reg_req.data & tsco_pkg::CH_EN_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data_reg <= 8'h00;
        end else if (reg_req.rd) begin
            rd_data_reg <= rd_mux;
        end
    end

    always_ff @(posedge clock) begin
        if (init) begin
            state_reg       <= tsco_pkg::SEQ_IDLE;
            ch_reg          <= '0;
            conv_start_reg  <= 1'b0;
            conv_enable_reg <= 1'b0;
            conv_ideal_reg  <= 1'b0;
            // The default configuration enforces the timeout, so it must not lapse on re-init.
            timeout_en_reg  <= 1'b1;
        end else begin
            state_reg       <= state_next;
            conv_start_reg  <= state_next == tsco_pkg::SEQ_START;
            conv_enable_reg <= run;
            timeout_en_reg  <= !cfg_reg.timeout_off;
            if (state_reg == tsco_pkg::SEQ_IDLE || abort || round_done) begin
                ch_reg <= '0;
            end else if (done_hit) begin
                ch_reg <= ch_reg + 1'b1;
            end
            if (state_next == tsco_pkg::SEQ_START) begin
                conv_ideal_reg <= state_reg != tsco_pkg::SEQ_IDLE && done_hit
                                  ? ideal_en_reg[ch_reg + 1'b1]
                                  : 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (init) begin
            raw_reg    <= '0;
            result_reg <= '0;
            cnt_reg    <= '0;
            fault_reg  <= '0;
            alert_reg  <= 1'b0;
            hot_reg    <= '0;
        end else begin
            if (done_hit) begin
                raw_reg[ch_reg]    <= conv_temp;
                result_reg[ch_reg] <= corr_val;
                cnt_reg[ch_reg]    <= cnt_upd;
            end
            fault_reg <= fault_next;
            hot_reg   <= hot_next;
            // In interrupt mode a new fault wins over an acknowledge in the same cycle.
            alert_reg <= cfg_reg.comparator ? |fault_next
                                            : fault_rise || (alert_reg && !alert_ack);
        end
    end

    assign rd_data           = rd_data_reg;
    assign conv_enable       = conv_enable_reg;
    assign conv_start        = conv_start_reg;
    assign conv_channel      = ch_reg;
    assign conv_ideal_custom = conv_ideal_reg;
    assign result            = result_reg;
    assign hottest           = hot_reg;
    assign fault             = fault_reg;
    assign therm_alert       = alert_reg;
    assign bus_timeout_en    = timeout_en_reg;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_single_req;
        wr_single && !rst;
    endsequence
    sequence s_round_end;
        cfg_reg.single_conversion_trigger && round_done && !wr_cfg;
    endsequence

    a_standby_stop: assert property ((!run) [*2] |-> !conv_enable && !conv_start)
        else $error("Converter active in standby.");
    a_reinit_restore: assert property (cfg_plain && reg_req.data[tsco_pkg::REINIT_BIT]
        |=> 8'(cfg_reg) == tsco_pkg::CONFIG_RST && offset_reg == tsco_pkg::OFFSET_RST)
        else $error("Re-initialise did not restore defaults.");
    a_timeout_pin: assert property (##1 bus_timeout_en == !$past(cfg_reg.timeout_off))
        else $error("Timeout enable does not follow its bit.");
    a_alert_comp: assert property ($past(cfg_reg.comparator) |-> therm_alert == |fault)
        else $error("Comparator alert not following faults.");
    a_single_clear: assert property (s_round_end |=> !cfg_reg.single_conversion_trigger)
        else $error("Single trigger not cleared after its round.");
    a_single_ignore: assert property (s_single_req
        |=> cfg_reg[7:1] == $past(cfg_reg[7:1]))
        else $error("Other bits taken with single trigger.");
    a_single_standby: assert property (cfg_reg.single_conversion_trigger
        |-> cfg_reg.standby)
        else $error("Single trigger held outside standby.");
    a_ideal_local: assert property (conv_start && conv_channel == '0
        |-> !conv_ideal_custom)
        else $error("Local channel given custom ideality.");
    a_reserved_zero: assert property (((ideal_en_reg | offset_en_reg)
        & ~tsco_pkg::CH_EN_MASK) == 8'h00)
        else $error("Reserved enable bit set.");
    a_fault_restart: assert property (done_hit && !exceed
        |=> cnt_reg[$past(ch_reg)] == 3'h0 && !fault[$past(ch_reg)])
        else $error("Fault counter not restarted.");
    a_clamp_max: assert property (done_hit && !cfg_reg.wide_span_select
        |=> $signed(result[$past(ch_reg)]) <= $signed(tsco_pkg::MAX_NORMAL))
        else $error("Result above normal span.");
    a_hot_raw: assert property (!init && $stable(raw_reg) && $stable(ref_temp)
        && $stable(hot_enable)
        |=> $stable(hottest))
        else $error("Hottest moved without a sample change.");
endmodule : tsco_core

/* common/tsco_pkg.sv */
// Constants, carriers and helpers of the sensor configuration and offset block.
// Contract
// - Standby bit set stops the converter; cleared (default) lets it run.
// - Writing the re-initialise bit restores power-on state; it always reads zero.
// - Bus timeout is enforced while its control bit is zero, the default.
// - Alert style bit: zero gives interrupt mode, one (default) gives comparator mode.
// - Fault raised after 1, 2, 4 or 6 consecutive faulting conversions per field.
// - Results clamp at +127.9375 C, or +191.9375 C with wide span selected.
// - Single conversion trigger runs exactly one round, then clears itself.
// - A configuration write setting the trigger ignores its other bits.
// - The trigger only works in standby; host sets standby first.
// - Per-remote ideality bit picks fixed 1.008 or the custom factor.
// - Offset code is unsigned; offset equals -14.875 C plus code over eight.
// - Offset code powers up as 77h, meaning zero offset.
// - Per-remote apply bit adds the custom offset only when set.
// - Hottest-channel result never includes the custom offset.
// - Hottest is the maximum of temperature minus reference over selected channels.
package tsco_pkg;
    localparam int         TEMP_W         = 13;
    localparam int         CH_W           = 2;
    localparam logic [7:0] ADDR_CONFIG    = 8'h13;
    localparam logic [7:0] ADDR_IDEAL_EN  = 8'h15;
    localparam logic [7:0] ADDR_OFFSET    = 8'h16;
    localparam logic [7:0] ADDR_OFFSET_EN = 8'h17;
    localparam logic [7:0] CONFIG_RST     = 8'h10;
    localparam logic [7:0] OFFSET_RST     = 8'h77;
    localparam logic [7:0] CH_EN_RST      = 8'h00;
    localparam logic [7:0] CH_EN_MASK     = 8'h0E;
    localparam logic [7:0] CONFIG_WR_MASK = 8'hBF;
    localparam int         REINIT_BIT     = 6;
    localparam int         SINGLE_BIT     = 0;
    // Temperatures are signed sixteenths of a degree.
    localparam logic [TEMP_W:0]   OFFSET_BASE = 14'h3F12;
    localparam logic [TEMP_W-1:0] MAX_NORMAL  = 13'h07FF;
    localparam logic [TEMP_W-1:0] MAX_WIDE    = 13'h0BFF;
    localparam logic [TEMP_W-1:0] TEMP_MIN    = 13'h1000;
    localparam logic [2:0]        FQ_NEED_0   = 3'h1;
    localparam logic [2:0]        FQ_NEED_1   = 3'h2;
    localparam logic [2:0]        FQ_NEED_2   = 3'h4;
    localparam logic [2:0]        FQ_NEED_3   = 3'h6;

    typedef struct packed {
        logic       standby;
        logic       reinit;
        logic       timeout_off;
        logic       comparator;
        logic [1:0] fault_queue;
        logic       wide_span_select;
        logic       single_conversion_trigger;
    } tsco_cfg_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } tsco_req_t;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT} tsco_seq_t;

    function automatic logic [2:0] fault_need(input logic [1:0] code);
        unique case (code)
            2'h0: fault_need = FQ_NEED_0;
            2'h1: fault_need = FQ_NEED_1;
            2'h2: fault_need = FQ_NEED_2;
            2'h3: fault_need = FQ_NEED_3;
        endcase
    endfunction : fault_need
endpackage : tsco_pkg

/* verification/tsco_conv_model.sv */
// Behavioural converter that answers each conversion start with a per-channel sample.
`timescale 1ns/1ns
module tsco_conv_model (
    input  wire logic                             clock,
    input  wire logic                             rst,
    input  wire logic                             conv_start,
    input  wire logic [tsco_pkg::CH_W-1:0]        conv_channel,
    input  wire logic                             conv_ideal_custom,
    input  wire logic                             slow,
    input  wire logic [3:0][tsco_pkg::TEMP_W-1:0] temps,
    output logic                                  conv_done,
    output logic [tsco_pkg::TEMP_W-1:0]           conv_temp,
    output int                                    n_start,
    output logic [3:0]                            ideal_seen
);
    int                        wait_cnt;
    logic [tsco_pkg::CH_W-1:0] ch_reg;

    // The sample toggles outside the done pulse so a late capture cannot pass by luck.
    always @(posedge clock) begin
        conv_done <= 1'b0;
        conv_temp <= ~conv_temp;
        if (rst) begin
            wait_cnt <= 0;
            n_start <= 0;
            ideal_seen <= 4'h0;
            conv_temp <= 13'h0000;
        end else if (conv_start) begin
            n_start <= n_start + 1;
            ch_reg <= conv_channel;
            ideal_seen[conv_channel] <= conv_ideal_custom;
            wait_cnt <= slow ? 6 : 1;
        end else if (wait_cnt == 1) begin
            wait_cnt <= 0;
            conv_done <= 1'b1;
            conv_temp <= temps[ch_reg];
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end
    end
endmodule : tsco_conv_model

/* verification/temp_sensor_config_offset_tb_top.sv */
// Self-checking bench of the configuration and offset block.
`timescale 1ns/1ns
module temp_sensor_config_offset_tb_top;
    logic                clock = 1'b0;
    logic                rst = 1'b1;
    tsco_pkg::tsco_req_t req = '0;
    logic [7:0]          rd_data;
    logic                conv_enable, conv_start, conv_ideal_custom, conv_done;
    logic [1:0]          conv_channel;
    logic [12:0]         conv_temp;
    logic [3:0][12:0]    limit_temp = {4{13'h0FFF}};
    logic [3:0][12:0]    ref_temp = {13'h0000, 13'h0000, 13'h0010, 13'h0000};
    logic [3:0][12:0]    temps = {13'h0C00, 13'h0100, 13'h0200, 13'h0190};
    logic [3:0][12:0]    result;
    logic [13:0]         hottest;
    logic [3:0]          fault, ideal_seen;
    logic [3:0]          hot_enable = 4'h7;
    logic                alert_ack = 1'b0;
    logic                slow = 1'b0;
    logic                therm_alert, bus_timeout_en, rd_pend = 1'b0;
    logic [7:0]          exp_q[$];
    logic [7:0]          code;
    int                  n_start, n0, cycles = 0, n_fail = 0, checked = 0;
    integer              seed = 32'hA8FB;

    always #20 clock = ~clock;

    tsco_core #(.NUM_CH(4)) uut (.clock(clock), .rst(rst), .reg_req(req), .rd_data(rd_data),
        .conv_enable(conv_enable), .conv_start(conv_start), .conv_channel(conv_channel),
        .conv_ideal_custom(conv_ideal_custom), .conv_done(conv_done), .conv_temp(conv_temp),
        .limit_temp(limit_temp), .ref_temp(ref_temp), .hot_enable(hot_enable),
        .alert_ack(alert_ack), .result(result), .hottest(hottest), .fault(fault),
        .therm_alert(therm_alert), .bus_timeout_en(bus_timeout_en));

    tsco_conv_model far (.clock(clock), .rst(rst), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_ideal_custom(conv_ideal_custom), .slow(slow),
        .temps(temps), .conv_done(conv_done), .conv_temp(conv_temp), .n_start(n_start),
        .ideal_seen(ideal_seen));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // Read data is registered on the taking edge, so the note is matched on the falling edge that follows it.
    always @(posedge clock) rd_pend <= req.rd;
    always @(negedge clock) if (rd_pend) check("rd_data", 16'(rd_data), 16'(exp_q.pop_front()));

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        req <= '{wr: w, rd: ~w, addr: a, data: d};
        @(negedge clock);
        req <= '0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd

    // A round is only legal from standby; the bench always sets standby first.
    task automatic one_round(input logic [7:0] d, input logic [7:0] cfg);
        n0 = n_start;
        bus(1'b1, 8'h13, d);
        for (int i = 0; i < 10 && conv_enable !== 1'b1; i++) @(negedge clock);
        for (int i = 0; i < 300 && conv_enable !== 1'b0; i++) @(negedge clock);
        repeat (2) @(negedge clock);
        check("rounds", 16'(n_start - n0), 16'h0004);
        rd(8'h13, cfg);
    endtask : one_round

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge clock);
        rst = 1'b0;
        rd(8'h13, 8'h10);
        rd(8'h15, 8'h00);
        rd(8'h16, 8'h77);
        rd(8'h17, 8'h00);
        rd(8'h20, 8'h00);
        check("timeout_en", 16'(bus_timeout_en), 16'h0001);
        check("conv_enable", 16'(conv_enable), 16'h0001);
        $display("test reset values done");
        bus(1'b1, 8'h13, 8'h01);
        rd(8'h13, 8'h10);
        bus(1'b1, 8'h13, 8'h30);
        repeat (2) @(negedge clock);
        check("timeout_en", 16'(bus_timeout_en), 16'h0000);
        bus(1'b1, 8'h13, 8'h90);
        repeat (20) @(negedge clock);
        n0 = n_start;
        repeat (20) @(negedge clock);
        check("standby starts", 16'(n_start - n0), 16'h0000);
        check("conv_enable", 16'(conv_enable), 16'h0000);
        check("timeout_en", 16'(bus_timeout_en), 16'h0001);
        $display("test standby done");
        code = 8'h80 | 8'($random(seed));
        bus(1'b1, 8'h15, 8'hF5);
        bus(1'b1, 8'h17, 8'hF3);
        bus(1'b1, 8'h16, code);
        rd(8'h15, 8'h04);
        rd(8'h17, 8'h02);
        rd(8'h16, code);
        one_round(8'hFF, 8'h90);
        check("result0", 16'(result[0]), 16'h0190);
        check("result1", 16'(result[1]), 16'(13'h0200 + {4'h0, code, 1'b0} - 13'h00EE));
        check("result2", 16'(result[2]), 16'h0100);
        check("result3", 16'(result[3]), 16'h07FF);
        check("hottest", 16'(hottest), 16'h01F0);
        check("ideality", 16'(ideal_seen), 16'h0004);
        $display("test single round done");
        bus(1'b1, 8'h13, 8'h92);
        slow = 1'b1;
        one_round(8'h01, 8'h92);
        check("result3 wide", 16'(result[3]), 16'h0BFF);
        $display("test wide span done");
        bus(1'b1, 8'h13, 8'h96);
        limit_temp[0] = 13'h0100;
        one_round(8'h01, 8'h96);
        check("fault first", 16'(fault), 16'h0000);
        one_round(8'h01, 8'h96);
        check("fault second", 16'(fault), 16'h0001);
        check("alert", 16'(therm_alert), 16'h0001);
        $display("test fault queue done");
        bus(1'b1, 8'h13, 8'h86);
        alert_ack = 1'b1;
        @(negedge clock);
        alert_ack = 1'b0;
        @(negedge clock);
        check("alert ack", 16'(therm_alert), 16'h0000);
        $display("test interrupt ack done");
        bus(1'b1, 8'h13, 8'h40);
        check("fault reinit", 16'(fault), 16'h0000);
        rd(8'h13, 8'h10);
        rd(8'h16, 8'h77);
        rd(8'h15, 8'h00);
        repeat (2) @(negedge clock);
        $display("test reinit done");
        complete_run();
    end
endmodule : temp_sensor_config_offset_tb_top
